// File: rtl/sfwec_pkg.sv
// package: opcodes, status layout, reset values and timing counts
package sfwec_pkg;

	// command opcodes
	localparam logic [7:0] AUTO_INCREMENT_PROGRAM = 8'haf;
	localparam logic [7:0] SECTOR_ERASE_CMD       = 8'h20;
	localparam logic [7:0] BLOCK_ERASE_CMD        = 8'h52;
	localparam logic [7:0] CHIP_ERASE_CMD         = 8'h60;
	localparam logic [7:0] STATUS_READ_CMD        = 8'h05;
	localparam logic [7:0] STATUS_WRITE_ARM_CMD   = 8'h50;
	localparam logic [7:0] STATUS_WRITE_CMD       = 8'h01;
	localparam logic [7:0] WRITE_ENABLE_CMD       = 8'h06;
	localparam logic [7:0] WRITE_DISABLE_CMD      = 8'h04;
	localparam logic [7:0] IDENT_READ_CMD_A       = 8'h90;
	localparam logic [7:0] IDENT_READ_CMD_B       = 8'hab;

	// framing
	localparam int BYTE_BITS  = 8;
	localparam int ADDR_BYTES = 3;
	localparam int ADDR_W     = 24;
	localparam int ADDR_MS    = 18;
	localparam int SECT_LSB   = 12;
	localparam int BLK_LSB    = 15;

	// status byte layout
	localparam int ST_BUSY = 0;
	localparam int ST_WEL  = 1;
	localparam int ST_BP0  = 2;
	localparam int ST_BP1  = 3;
	localparam int ST_AUTO = 6;
	localparam int ST_BPL  = 7;

	// reset values of the protection bits
	localparam logic [1:0] PROT_LEVEL_RST = 2'h0;
	localparam logic       PROT_LOCK_RST  = 1'h0;

	// identification codes; values are arbitrary
	localparam logic [7:0] MAKER_CODE = 8'h5a;
	localparam logic [7:0] PART_CODE  = 8'h3c;

	// internal step times and their cycle counts
	localparam int CLK_MHZ       = 200;
	localparam int T_PROG_US     = 20;
	localparam int T_SECT_US     = 25000;
	localparam int T_BLK_US      = 25000;
	localparam int T_CHIP_US     = 100000;
	localparam int PROG_CYC      = T_PROG_US * CLK_MHZ;
	localparam int SECT_CYC      = T_SECT_US * CLK_MHZ;
	localparam int BLK_CYC       = T_BLK_US * CLK_MHZ;
	localparam int CHIP_CYC      = T_CHIP_US * CLK_MHZ;
	localparam int TIMER_W       = 32;

	typedef enum logic [1:0] {
		K_PROG = 2'h0,
		K_SECT = 2'h1,
		K_BLK  = 2'h3,
		K_CHIP = 2'h2
	} sfwec_kind_t;

	typedef enum logic [1:0] {
		FR_OPC  = 2'h0,
		FR_ADDR = 2'h1,
		FR_DATA = 2'h3,
		FR_OUT  = 2'h2
	} sfwec_frame_t;

endpackage

// File: rtl/sfwec_link_if.sv
// interface: bytes between the serial-clock shifter and the core
`timescale 1ns/1ps
interface sfwec_link_if;
	logic [7:0] rx_byte;
	logic       rx_tgl;
	logic [7:0] tx_byte;
	logic       tx_valid;

	modport link (output rx_byte, output rx_tgl, input tx_byte, input tx_valid);
	modport core (input rx_byte, input rx_tgl, output tx_byte, output tx_valid);
endinterface

// File: rtl/sfwec_timer.sv
// module: countdown that holds busy for one internal step
`timescale 1ns/1ps
module sfwec_timer #(
	parameter int W = sfwec_pkg::TIMER_W
) (
	// clock and reset
	input  wire logic         clk,
	input  wire logic         rst,
	// control
	input  wire logic         start,
	input  wire logic [W-1:0] load,
	// state
	output logic              busy
);

	logic [W-1:0] cnt_ff;
	logic         busy_ff;

	always_ff @(posedge clk) begin
		if (rst) begin
			cnt_ff <= '0;
		end else if (start) begin
			cnt_ff <= load;
		end else if (cnt_ff != '0) begin
			cnt_ff <= cnt_ff - W'(1);
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			busy_ff <= 1'b0;
		end else if (start) begin
			busy_ff <= 1'b1;
		end else if (cnt_ff <= W'(1)) begin
			busy_ff <= 1'b0;
		end
	end

	assign busy = busy_ff;

endmodule

// File: rtl/sfwec_link.sv
// module: serial shifter on the host clock, bytes in and out
`timescale 1ns/1ps
module sfwec_link (
	// serial pins
	input  wire logic   sck,
	input  wire logic   ce_n,
	input  wire logic   si,
	output logic        so,
	output logic        so_oe_n,
	// reset from the core domain
	input  wire logic   rst,
	// byte side
	sfwec_link_if.link  lk
);

	logic       frame_rst;
	logic [2:0] bit_cnt_ff;
	logic [6:0] rx_sh_ff;
	logic [7:0] rx_byte_ff;
	logic       rx_tgl_ff;
	logic [7:0] tx_sh_ff;
	logic       oe_n_ff;

	// the host clock stops between frames, so the frame itself resets
	assign frame_rst = ce_n | rst;

	always_ff @(posedge sck or posedge frame_rst) begin
		if (frame_rst) begin
			bit_cnt_ff <= 3'h0;
		end else begin
			bit_cnt_ff <= bit_cnt_ff + 3'h1;
		end
	end

	always_ff @(posedge sck or posedge rst) begin
		if (rst) begin
			rx_sh_ff <= 7'h00;
		end else begin
			rx_sh_ff <= {rx_sh_ff[5:0], si};
		end
	end

	// the toggle is not cleared by chip select: that would fake an event
	always_ff @(posedge sck or posedge rst) begin
		if (rst) begin
			rx_byte_ff <= 8'h00;
			rx_tgl_ff  <= 1'b0;
		end else if (bit_cnt_ff == 3'h7) begin
			rx_byte_ff <= {rx_sh_ff, si};
			rx_tgl_ff  <= ~rx_tgl_ff;
		end
	end

	// tx word is quasi-static: written after the previous byte ends, before the falling edge that loads it
	always_ff @(negedge sck or posedge frame_rst) begin
		if (frame_rst) begin
			tx_sh_ff <= 8'hff;
			oe_n_ff  <= 1'b1;
		end else if (bit_cnt_ff == 3'h0) begin
			tx_sh_ff <= lk.tx_byte;
			oe_n_ff  <= ~lk.tx_valid;
		end else begin
			tx_sh_ff <= {tx_sh_ff[6:0], 1'b1};
		end
	end

	assign so         = tx_sh_ff[7];
	assign so_oe_n    = oe_n_ff;
	assign lk.rx_byte = rx_byte_ff;
	assign lk.rx_tgl  = rx_tgl_ff;

endmodule

// File: rtl/sfwec_core.sv
// module: command decode, write latch, protection and step control
//
// Overview of operation
// - auto program into protected start is dropped
// - auto program: opcode, 24-bit address, data byte
// - continuation: opcode and data, next address
// - steps start at chip select rise, host polls
// - no wrap: last unprotected address exits, latch clears
// - sector erase clears 4 KByte at address
// - block erase clears 32 KByte at address
// - erase into protected region is ignored
// - chip erase ignored if any level set
// - status read accepted at any time
// - status bytes repeat until chip select rises
// - write enable sets latch at select rise
// - write disable clears latch and auto mode
// - arming only valid for the very next command
// - status write changes only level and lock bits
// - locked and protect pin low: status write ignored
// - pin low: lock may set, never clear
// - unlocked or pin high: all three bits update
// - ident read alternates maker and part codes
// - every byte takes eight serial clocks
// - address bit zero picks maker or part
`timescale 1ns/1ps
module sfwec_core #(
	parameter int          ADDR_MS  = sfwec_pkg::ADDR_MS,
	parameter int unsigned PROG_CYC = sfwec_pkg::PROG_CYC,
	parameter int unsigned SECT_CYC = sfwec_pkg::SECT_CYC,
	parameter int unsigned BLK_CYC  = sfwec_pkg::BLK_CYC,
	parameter int unsigned CHIP_CYC = sfwec_pkg::CHIP_CYC
) (
	// system
	input  wire logic             CLOCK,
	input  wire logic             SYS_RST,
	// serial link
	input  wire logic             SCK,
	input  wire logic             CE_N,
	input  wire logic             SI,
	input  wire logic             WP_N,
	output logic                  SO,
	output logic                  SO_OE_N,
	// array step request
	output logic                  ARR_START,
	output sfwec_pkg::sfwec_kind_t ARR_KIND,
	output logic [23:0]           ARR_ADDR,
	output logic [7:0]            ARR_DATA,
	// status
	output logic                  BUSY,
	output logic                  WRITE_LATCH_BIT,
	output logic                  AUTO_INCREMENT_PROGRAM,
	output logic                  PROTECT_LEVEL_BIT0,
	output logic                  PROTECT_LEVEL_BIT1,
	output logic                  PROTECT_LOCK_BIT
);

	localparam int AW = ADDR_MS + 1;

	sfwec_link_if lk ();

	logic [2:0]               ce_sync_ff;
	logic [2:0]               tgl_sync_ff;
	logic [1:0]               wp_sync_ff;
	logic                     ce_rise;
	logic                     rx_evt;
	logic                     wp_low;
	sfwec_pkg::sfwec_frame_t  frame_ff;
	logic [1:0]               addr_cnt_ff;
	logic [7:0]               opcode_ff;
	logic [23:0]              addr_ff;
	logic [7:0]               data_ff;
	logic                     got_addr_ff;
	logic                     data_ok_ff;
	logic                     id_sel_ff;
	logic [7:0]               tx_byte_ff;
	logic                     tx_valid_ff;
	logic                     wel_ff;
	logic                     auto_ff;
	logic [AW-1:0]            prog_addr_ff;
	logic                     armed_ff;
	logic [1:0]               level_ff;
	logic                     lock_ff;
	logic                     busy;
	logic                     had_op;
	logic [AW-1:0]            prog_addr_nxt;
	logic [AW-1:0]            top_unprot;
	logic                     prog_ok;
	logic                     sect_ok;
	logic                     blk_ok;
	logic                     chip_ok;
	logic                     wsr_ok;
	logic                     step_go;
	sfwec_pkg::sfwec_kind_t   kind_nxt;
	logic [31:0]              load_nxt;
	logic [7:0]               status_now;

	////////////////////////////////////////////////////////////////////
	// helpers

	// lowest protected address; level 0 protects nothing
	function automatic logic [AW:0] prot_base(input logic [1:0] lvl);
		logic [AW:0] mem;
		mem = (AW+1)'(1) << AW;
		unique case (lvl)
			2'h0: prot_base = mem;
			2'h1: prot_base = mem - (mem >> 2);
			2'h2: prot_base = mem - (mem >> 1);
			2'h3: prot_base = '0;
		endcase
	endfunction

	// boundaries are at least 32 KByte aligned, so the addressed byte
	// decides for a whole sector or block
	function automatic logic is_prot(input logic [AW-1:0] a,
			input logic [1:0] lvl);
		is_prot = {1'b0, a} >= prot_base(lvl);
	endfunction

	function automatic logic is_ident(input logic [7:0] op);
		is_ident = (op == sfwec_pkg::IDENT_READ_CMD_A) ||
			(op == sfwec_pkg::IDENT_READ_CMD_B);
	endfunction

	function automatic logic [7:0] id_byte(input logic sel);
		id_byte = sel ? sfwec_pkg::PART_CODE : sfwec_pkg::MAKER_CODE;
	endfunction

	////////////////////////////////////////////////////////////////////
	// synchronisers: pins and the shifter toggle

	always_ff @(posedge CLOCK) begin
		if (SYS_RST) begin
			ce_sync_ff <= 3'h7;
		end else begin
			ce_sync_ff <= {ce_sync_ff[1:0], CE_N};
		end
	end

	always_ff @(posedge CLOCK) begin
		if (SYS_RST) begin
			tgl_sync_ff <= 3'h0;
		end else begin
			tgl_sync_ff <= {tgl_sync_ff[1:0], lk.rx_tgl};
		end
	end

	always_ff @(posedge CLOCK) begin
		if (SYS_RST) begin
			wp_sync_ff <= 2'h3;
		end else begin
			wp_sync_ff <= {wp_sync_ff[0], WP_N};
		end
	end

	assign ce_rise = ce_sync_ff[1] & ~ce_sync_ff[2];
	assign rx_evt  = tgl_sync_ff[1] ^ tgl_sync_ff[2];
	assign wp_low  = ~wp_sync_ff[1];

	////////////////////////////////////////////////////////////////////
	// frame parsing

	assign status_now = {lock_ff, auto_ff, 2'h0, level_ff, wel_ff, busy};

	always_ff @(posedge CLOCK) begin
		if (SYS_RST || ce_rise) begin
			frame_ff    <= sfwec_pkg::FR_OPC;
			addr_cnt_ff <= 2'h0;
			got_addr_ff <= 1'b0;
			data_ok_ff  <= 1'b0;
			tx_valid_ff <= 1'b0;
			id_sel_ff   <= 1'b0;
		end else if (rx_evt) begin
			unique case (frame_ff)
				sfwec_pkg::FR_OPC: begin
					if (lk.rx_byte == sfwec_pkg::STATUS_READ_CMD) begin
						frame_ff    <= sfwec_pkg::FR_OUT;
						tx_valid_ff <= 1'b1;
					end else if ((lk.rx_byte ==
							sfwec_pkg::AUTO_INCREMENT_PROGRAM && !auto_ff) ||
							lk.rx_byte == sfwec_pkg::SECTOR_ERASE_CMD ||
							lk.rx_byte == sfwec_pkg::BLOCK_ERASE_CMD ||
							is_ident(lk.rx_byte)) begin
						frame_ff <= sfwec_pkg::FR_ADDR;
					end else begin
						frame_ff <= sfwec_pkg::FR_DATA;
					end
				end
				sfwec_pkg::FR_ADDR: begin
					addr_cnt_ff <= addr_cnt_ff + 2'h1;
					if (addr_cnt_ff == 2'(sfwec_pkg::ADDR_BYTES - 1)) begin
						got_addr_ff <= 1'b1;
						if (is_ident(opcode_ff)) begin
							frame_ff    <= sfwec_pkg::FR_OUT;
							tx_valid_ff <= 1'b1;
							id_sel_ff   <= ~lk.rx_byte[0];
						end else begin
							frame_ff <= sfwec_pkg::FR_DATA;
						end
					end
				end
				sfwec_pkg::FR_DATA: begin
					data_ok_ff <= 1'b1;
				end
				sfwec_pkg::FR_OUT: begin
					id_sel_ff <= ~id_sel_ff;
				end
			endcase
		end
	end

	// byte payloads; extra trailing bytes are ignored
	always_ff @(posedge CLOCK) begin
		if (SYS_RST) begin
			opcode_ff  <= 8'h00;
			addr_ff    <= 24'h000000;
			data_ff    <= 8'hff;
			tx_byte_ff <= 8'h00;
		end else if (rx_evt) begin
			unique case (frame_ff)
				sfwec_pkg::FR_OPC: begin
					opcode_ff  <= lk.rx_byte;
					tx_byte_ff <= status_now;
				end
				sfwec_pkg::FR_ADDR: begin
					addr_ff    <= {addr_ff[15:0], lk.rx_byte};
					tx_byte_ff <= id_byte(lk.rx_byte[0]);
				end
				sfwec_pkg::FR_DATA: begin
					if (!data_ok_ff) begin
						data_ff <= lk.rx_byte;
					end
				end
				sfwec_pkg::FR_OUT: begin
					// status is resampled for every byte so busy can fall
					tx_byte_ff <= is_ident(opcode_ff) ? id_byte(id_sel_ff)
						: status_now;
				end
			endcase
		end
	end

	assign lk.tx_byte  = tx_byte_ff;
	assign lk.tx_valid = tx_valid_ff;

	////////////////////////////////////////////////////////////////////
	// execution at chip select rise

	assign had_op        = frame_ff != sfwec_pkg::FR_OPC;
	assign top_unprot    = AW'(prot_base(level_ff) - (AW+1)'(1));
	assign prog_addr_nxt = auto_ff ? prog_addr_ff + AW'(1)
		: addr_ff[AW-1:0];

	assign prog_ok = ce_rise && had_op && !busy && wel_ff && data_ok_ff &&
		opcode_ff == sfwec_pkg::AUTO_INCREMENT_PROGRAM &&
		(auto_ff || (got_addr_ff &&
		!is_prot(addr_ff[AW-1:0], level_ff)));
	assign sect_ok = ce_rise && had_op && !busy && wel_ff && got_addr_ff &&
		opcode_ff == sfwec_pkg::SECTOR_ERASE_CMD &&
		!is_prot(addr_ff[AW-1:0], level_ff);
	assign blk_ok = ce_rise && had_op && !busy && wel_ff && got_addr_ff &&
		opcode_ff == sfwec_pkg::BLOCK_ERASE_CMD &&
		!is_prot(addr_ff[AW-1:0], level_ff);
	assign chip_ok = ce_rise && had_op && !busy && wel_ff &&
		opcode_ff == sfwec_pkg::CHIP_ERASE_CMD && level_ff == 2'h0;
	assign wsr_ok = ce_rise && had_op && armed_ff && data_ok_ff &&
		opcode_ff == sfwec_pkg::STATUS_WRITE_CMD &&
		!(wp_low && lock_ff);
	assign step_go = prog_ok | sect_ok | blk_ok | chip_ok;

	always_comb begin
		kind_nxt = sfwec_pkg::K_PROG;
		load_nxt = PROG_CYC;
		if (sect_ok) begin
			kind_nxt = sfwec_pkg::K_SECT;
			load_nxt = SECT_CYC;
		end else if (blk_ok) begin
			kind_nxt = sfwec_pkg::K_BLK;
			load_nxt = BLK_CYC;
		end else if (chip_ok) begin
			kind_nxt = sfwec_pkg::K_CHIP;
			load_nxt = CHIP_CYC;
		end
	end

	// write latch and auto mode
	always_ff @(posedge CLOCK) begin
		if (SYS_RST) begin
			wel_ff       <= 1'b0;
			auto_ff      <= 1'b0;
			prog_addr_ff <= '0;
		end else if (ce_rise && had_op) begin
			if (opcode_ff == sfwec_pkg::WRITE_ENABLE_CMD) begin
				wel_ff <= 1'b1;
			end else if (opcode_ff == sfwec_pkg::WRITE_DISABLE_CMD) begin
				wel_ff  <= 1'b0;
				auto_ff <= 1'b0;
			end else if (prog_ok) begin
				wel_ff       <= prog_addr_nxt != top_unprot;
				auto_ff      <= prog_addr_nxt != top_unprot;
				prog_addr_ff <= prog_addr_nxt;
			end else if (sect_ok || blk_ok || chip_ok) begin
				wel_ff <= 1'b0;
			end
		end
	end

	// arming and protection bits
	always_ff @(posedge CLOCK) begin
		if (SYS_RST) begin
			armed_ff <= 1'b0;
			level_ff <= sfwec_pkg::PROT_LEVEL_RST;
			lock_ff  <= sfwec_pkg::PROT_LOCK_RST;
		end else if (ce_rise && had_op) begin
			armed_ff <= opcode_ff == sfwec_pkg::STATUS_WRITE_ARM_CMD;
			if (wsr_ok) begin
				level_ff <= {data_ff[sfwec_pkg::ST_BP1],
					data_ff[sfwec_pkg::ST_BP0]};
				lock_ff  <= data_ff[sfwec_pkg::ST_BPL];
			end
		end
	end

	// step request to the array
	always_ff @(posedge CLOCK) begin
		if (SYS_RST) begin
			ARR_START <= 1'b0;
			ARR_KIND  <= sfwec_pkg::K_PROG;
			ARR_ADDR  <= 24'h000000;
			ARR_DATA  <= 8'hff;
		end else begin
			ARR_START <= step_go;
			if (step_go) begin
				ARR_KIND <= kind_nxt;
				ARR_DATA <= data_ff;
				if (sect_ok) begin
					ARR_ADDR <= {addr_ff[23:sfwec_pkg::SECT_LSB],
						12'h000};
				end else if (blk_ok) begin
					ARR_ADDR <= {addr_ff[23:sfwec_pkg::BLK_LSB],
						15'h0000};
				end else if (chip_ok) begin
					ARR_ADDR <= 24'h000000;
				end else begin
					ARR_ADDR <= 24'(prog_addr_nxt);
				end
			end
		end
	end

	sfwec_timer #(
		.W     (sfwec_pkg::TIMER_W)
	) u_timer (
		.clk   (CLOCK),
		.rst   (SYS_RST),
		.start (step_go),
		.load  (load_nxt),
		.busy  (busy)
	);

	sfwec_link u_link (
		.sck     (SCK),
		.ce_n    (CE_N),
		.si      (SI),
		.so      (SO),
		.so_oe_n (SO_OE_N),
		.rst     (SYS_RST),
		.lk      (lk.link)
	);

	assign BUSY                   = busy;
	assign WRITE_LATCH_BIT        = wel_ff;
	assign AUTO_INCREMENT_PROGRAM = auto_ff;
	assign PROTECT_LEVEL_BIT0     = level_ff[0];
	assign PROTECT_LEVEL_BIT1     = level_ff[1];
	assign PROTECT_LOCK_BIT       = lock_ff;

	////////////////////////////////////////////////////////////////////
	// assertions

	default clocking cb @(posedge CLOCK); endclocking
	default disable iff (SYS_RST);

	sequence s_frame_end(logic [7:0] op);
		ce_rise && had_op && opcode_ff == op;
	endsequence

	sequence s_locked_write;
		s_frame_end(sfwec_pkg::STATUS_WRITE_CMD) ##0 wp_low && lock_ff;
	endsequence

	property p_write_enable_cmd_sets;
		s_frame_end(sfwec_pkg::WRITE_ENABLE_CMD) |=> wel_ff;
	endproperty
	a_write_enable_cmd_sets: assert property (p_write_enable_cmd_sets)
		else $error("write enable did not set the latch");

	property p_write_disable_cmd_clears;
		s_frame_end(sfwec_pkg::WRITE_DISABLE_CMD) |=> !wel_ff && !auto_ff;
	endproperty
	a_write_disable_cmd_clears: assert property (p_write_disable_cmd_clears)
		else $error("write disable left latch or auto mode set");

	property p_prot_start;
		s_frame_end(sfwec_pkg::AUTO_INCREMENT_PROGRAM) ##0 !auto_ff ##0
			is_prot(addr_ff[AW-1:0], level_ff) |=> !ARR_START;
	endproperty
	a_prot_start: assert property (p_prot_start)
		else $error("program into protected region was started");

	property p_need_wel;
		ARR_START |-> $past(wel_ff) && !$past(busy);
	endproperty
	a_need_wel: assert property (p_need_wel)
		else $error("step started without write latch");

	property p_busy_hold;
		ARR_START |-> BUSY [*8];
	endproperty
	a_busy_hold: assert property (p_busy_hold)
		else $error("busy dropped early in a step");

	property p_chip_prot;
		ARR_START && ARR_KIND == sfwec_pkg::K_CHIP |->
			$past(level_ff) == 2'h0;
	endproperty
	a_chip_prot: assert property (p_chip_prot)
		else $error("chip erase ran with protection set");

	property p_lock_holds;
		s_locked_write |=> $stable({lock_ff, level_ff}) [*2];
	endproperty
	a_lock_holds: assert property (p_lock_holds)
		else $error("locked status register changed");

	property p_arm_once;
		ce_rise && had_op &&
			opcode_ff != sfwec_pkg::STATUS_WRITE_ARM_CMD |=> !armed_ff;
	endproperty
	a_arm_once: assert property (p_arm_once)
		else $error("arming survived another command");

	property p_no_wrap;
		ARR_START && ARR_KIND == sfwec_pkg::K_PROG &&
			ARR_ADDR == 24'(top_unprot) |-> !auto_ff && !wel_ff;
	endproperty
	a_no_wrap: assert property (p_no_wrap)
		else $error("auto program continued past last address");

	property p_next_addr;
		ARR_START && ARR_KIND == sfwec_pkg::K_PROG && $past(auto_ff) |->
			ARR_ADDR == 24'($past(prog_addr_ff) + AW'(1));
	endproperty
	a_next_addr: assert property (p_next_addr)
		else $error("auto program address did not step by one");

endmodule

// File: bench/sfwec_host.sv
// host serial master model: frames commands and collects returned bytes
`timescale 1ns/1ps
module sfwec_host (
	// serial pins
	output logic      sck,
	output logic      ce_n,
	output logic      si,
	input  wire logic so,
	input  wire logic so_oe_n
);
	logic [7:0] rx[$];
	logic       last_oe;

	initial begin
		sck  = 1'b0;
		ce_n = 1'b1;
		si   = 1'b0;
	end

	// mode 0: shift on fall, sample on rise; clock stands low between frames
	task automatic xfer(input logic [7:0] tx[$], input int extra);
		logic [7:0] b;
		logic [7:0] r;
		rx.delete();
		#3.3 ce_n = 1'b0;
		for (int i = 0; i < tx.size() + extra; i++) begin
			b = (i < tx.size()) ? tx[i] : 8'h00;
			for (int k = 7; k >= 0; k--) begin
				si = b[k];
				#62.5 sck = 1'b1;
				r = {r[6:0], so};
				last_oe = so_oe_n;
				#62.5 sck = 1'b0;
			end
			rx.push_back(r);
		end
		// select rise executes the command; keep the gap long for decode
		#40 ce_n = 1'b1;
		si = ~si;
		#250;
	endtask
endmodule

// File: bench/serial_flash_write_erase_cmds_bench.sv
// testbench: command sequences over the serial link with expected results
`timescale 1ns/1ps
module serial_flash_write_erase_cmds_bench;
	logic                   clk = 1'b0;
	logic                   rst = 1'b1;
	logic                   wp_n = 1'b1;
	wire logic              sck, ce_n, si, so, so_oe_n, arr_start, busy;
	wire logic              write_latch_bit, auto, lv0, lv1, lock;
	sfwec_pkg::sfwec_kind_t arr_kind;
	wire logic [23:0]       arr_addr;
	wire logic [7:0]        arr_data;
	int                     n_errors, n_tests, n_start, cyc;
	logic [1:0]             s_kind;
	logic [23:0]            s_addr;
	logic [7:0]             s_data;
	sfwec_pkg::sfwec_kind_t ek[3] = '{sfwec_pkg::K_SECT, sfwec_pkg::K_BLK,
		sfwec_pkg::K_CHIP};
	logic [23:0]            ea[3] = '{24'h012000, 24'h010000, 24'h000000};
	logic [7:0]             eo[3] = '{8'h20, 8'h52, 8'h60};

	always #2.5 clk = ~clk;

	// step times must outlast the command gap, and the chip erase time a whole status frame,
	// so busy is still seen high where the tests expect it
	sfwec_core #(.PROG_CYC(100), .SECT_CYC(200), .BLK_CYC(200),
		.CHIP_CYC(1000)) dut (.CLOCK(clk), .SYS_RST(rst), .SCK(sck),
		.CE_N(ce_n), .SI(si), .WP_N(wp_n), .SO(so), .SO_OE_N(so_oe_n),
		.ARR_START(arr_start), .ARR_KIND(arr_kind), .ARR_ADDR(arr_addr),
		.ARR_DATA(arr_data), .BUSY(busy), .WRITE_LATCH_BIT(write_latch_bit),
		.AUTO_INCREMENT_PROGRAM(auto), .PROTECT_LEVEL_BIT0(lv0),
		.PROTECT_LEVEL_BIT1(lv1), .PROTECT_LOCK_BIT(lock));

	sfwec_host host (.sck(sck), .ce_n(ce_n), .si(si), .so(so),
		.so_oe_n(so_oe_n));

	////////////////////////////////////////////////////////////////////////
	always @(posedge clk) begin
		if (arr_start === 1'b1) begin
			n_start <= n_start + 1;
			s_kind  <= arr_kind;
			s_addr  <= arr_addr;
			s_data  <= arr_data;
		end
	end

	// about 40 frames of a few microseconds each fit well inside this
	always @(posedge clk) begin
		cyc++;
		if (cyc == 60000) begin
			n_errors++;
			final_report();
		end
	end

	////////////////////////////////////////////////////////////////////////
	function automatic logic [7:0] st(logic b, w, logic [1:0] l, logic a, k);
		st = 8'h00;
		st[sfwec_pkg::ST_BUSY] = b;
		st[sfwec_pkg::ST_WEL]  = w;
		st[sfwec_pkg::ST_BP0]  = l[0];
		st[sfwec_pkg::ST_BP1]  = l[1];
		st[sfwec_pkg::ST_AUTO] = a;
		st[sfwec_pkg::ST_BPL]  = k;
	endfunction

	task automatic chk(input string nm, input logic [23:0] e, g);
		n_tests++;
		if (g !== e) begin
			n_errors++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic cmd(input logic [7:0] tx[$]);
		host.xfer(tx, 0);
		repeat (8) @(negedge clk);
	endtask

	// two status bytes: the second shows the stream keeps going
	task automatic status(input logic [7:0] e);
		host.xfer('{sfwec_pkg::STATUS_READ_CMD}, 2);
		chk("status", e, host.rx[1]);
		chk("status_again", e, host.rx[2]);
		chk("flags", e[7:1], {lock, auto, 2'h0, lv1, lv0, write_latch_bit});
		chk("oe_drive", 0, host.last_oe);
		chk("oe_idle", 1, so_oe_n);
	endtask

	task automatic start(input int n, input logic [1:0] k, input logic [23:0] a);
		chk("starts", n, n_start);
		chk("kind", k, s_kind);
		chk("addr", a, s_addr);
	endtask

	task automatic idle();
		for (int i = 0; i < 1000 && busy !== 1'b0; i++) @(negedge clk);
		chk("busy_done", 0, busy);
	endtask

	task automatic swr(input logic [7:0] d);
		cmd('{sfwec_pkg::STATUS_WRITE_ARM_CMD});
		cmd('{sfwec_pkg::STATUS_WRITE_CMD, d});
	endtask

	task automatic final_report();
		$display("errors %0d tests %0d", n_errors, n_tests);
		if (n_errors == 0 && n_tests > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (12) @(negedge clk);
		rst = 1'b0;
		repeat (4) @(negedge clk);
		status(st(0, 0, 0, 0, 0));
		cmd('{8'haf, 8'h00, 8'h10, 8'h00, 8'h5a});
		chk("no_start", 0, n_start);
		cmd('{8'h06});
		status(st(0, 1, 0, 0, 0));
		cmd('{8'haf, 8'h00, 8'h10, 8'h00, 8'h5a});
		start(1, sfwec_pkg::K_PROG, 24'h001000);
		chk("data", 8'h5a, s_data);
		chk("busy", 1, busy);
		chk("auto", 1, auto);
		idle();
		cmd('{8'haf, 8'ha5});
		start(2, sfwec_pkg::K_PROG, 24'h001001);
		chk("data", 8'ha5, s_data);
		idle();
		cmd('{8'h04});
		status(st(0, 0, 0, 0, 0));
		for (int i = 0; i < 3; i++) begin
			cmd('{8'h06});
			if (i < 2) cmd('{eo[i], 8'h01, 8'h2f, 8'hff});
			else cmd('{eo[i]});
			start(3 + i, ek[i], ea[i]);
			if (i == 2) status(st(1, 0, 0, 0, 0));
			idle();
		end
		cmd('{sfwec_pkg::STATUS_WRITE_CMD, 8'h04});
		status(st(0, 0, 0, 0, 0));
		cmd('{sfwec_pkg::STATUS_WRITE_ARM_CMD});
		cmd('{8'h06});
		cmd('{sfwec_pkg::STATUS_WRITE_CMD, 8'h04});
		status(st(0, 1, 0, 0, 0));
		cmd('{8'h04});
		@(negedge clk) wp_n = 1'b0;
		swr(8'hff);
		status(st(0, 0, 2'h3, 0, 1));
		swr(8'h04);
		status(st(0, 0, 2'h3, 0, 1));
		@(negedge clk) wp_n = 1'b1;
		swr(8'h04);
		status(st(0, 0, 2'h1, 0, 0));
		cmd('{8'h06});
		cmd('{8'h20, 8'h07, 8'h00, 8'h00});
		cmd('{8'h60});
		cmd('{8'haf, 8'h07, 8'h00, 8'h00, 8'h11});
		chk("refused", 5, n_start);
		cmd('{8'haf, 8'h05, 8'hff, 8'hff, 8'h3c});
		start(6, sfwec_pkg::K_PROG, 24'h05ffff);
		idle();
		status(st(0, 0, 2'h1, 0, 0));
		for (int j = 0; j < 2; j++) begin
			host.xfer('{j ? 8'hab : 8'h90, 8'h00, 8'h00, 8'(j)}, 3);
			chk("id0", j ? sfwec_pkg::PART_CODE : sfwec_pkg::MAKER_CODE,
				host.rx[4]);
			chk("id1", j ? sfwec_pkg::MAKER_CODE : sfwec_pkg::PART_CODE,
				host.rx[5]);
			chk("id2", j ? sfwec_pkg::PART_CODE : sfwec_pkg::MAKER_CODE,
				host.rx[6]);
		end
		final_report();
	end
endmodule
